// *** twp_slave.sv ***
// Purpose: two-wire slave front end of a quad digital potentiometer
// Assumes: bus pins sampled on link_clk; user side on core_clk
// Notes:   decoded writes leave as a one-cycle pulse with stable fields
`timescale 1ns/1ps
`default_nettype none
module twp_slave #(
	parameter logic [twp_pkg::TMR_W-1:0] NV_PROGRAM_CYCLES_P =
		twp_pkg::TMR_W'(twp_pkg::NV_PROGRAM_CYCLES),
	parameter logic [twp_pkg::TMR_W-1:0] POWERUP_CYCLES_P =
		twp_pkg::TMR_W'(twp_pkg::POWERUP_CYCLES)
)
(
	input  wire logic       core_clk,
	input  wire logic       rstn,
	input  wire logic       link_clk,
	input  wire logic       scl_i,
	input  wire logic       sda_i,
	output var  logic       sda_o,
	output var  logic       sda_oe_n,
	input  wire logic       wp_n_i,
	input  wire logic [3:0] addr_strap_pins,
	input  wire logic [7:0] rd_data,
	output var  logic       wr_valid,
	output var  logic [3:0] wr_opcode,
	output var  logic [1:0] data_reg_select_bits,
	output var  logic [3:0] data_reg_onehot,
	output var  logic [1:0] wr_pot_sel,
	output var  logic [7:0] wr_data,
	output var  logic       nv_busy
);
	import twp_pkg::*;

	typedef struct packed {
		twp_link_st_t st;
		logic [3:0]   bit_cnt;
		logic [7:0]   shreg;
		logic [7:0]   instr;
		logic [7:0]   data;
		logic         have_data;
		logic         wp_lost;
		logic         ev_tog;
		logic         rd_lock;
		logic         scl_prev;
		logic         sda_prev;
		logic         sda_oe_n;
		logic         sda_out;
	} twp_link_t;

	typedef struct packed {
		logic       tog_seen;
		logic       wr_valid;
		logic [3:0] opcode;
		logic [1:0] reg_sel;
		logic [3:0] reg_onehot;
		logic [1:0] pot_sel;
		logic [7:0] data;
		logic [7:0] rd_hold;
	} twp_core_t;

	localparam twp_link_t LINK_RST = '{
		st: ST_IDLE, scl_prev: 1'b1, sda_prev: 1'b1,
		sda_oe_n: 1'b1, default: '0};

	twp_link_t l_q;
	twp_link_t l_d;
	twp_core_t c_q;
	twp_core_t c_d;

	logic       scl_l;
	logic       sda_l;
	logic       wp_l;
	logic       busy_l;
	logic [3:0] strap_l;
	logic       tog_c;
	logic       lock_c;
	logic       tmr_start;
	logic       tmr_busy;

	// link-side synchronisers
	// glitch filtering
	twp_sync3 #(.RST_VAL(1'b1)) u_scl (
		.clk  (link_clk),
		.rstn (rstn),
		.din  (scl_i),
		.dout (scl_l)
	);
	twp_sync3 #(.RST_VAL(1'b1)) u_sda (
		.clk  (link_clk),
		.rstn (rstn),
		.din  (sda_i),
		.dout (sda_l)
	);
	twp_sync3 #(.RST_VAL(1'b1)) u_wp (
		.clk  (link_clk),
		.rstn (rstn),
		.din  (wp_n_i),
		.dout (wp_l)
	);
	twp_sync3 #(.RST_VAL(1'b1)) u_busy (
		.clk  (link_clk),
		.rstn (rstn),
		.din  (tmr_busy),
		.dout (busy_l)
	);

	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_strap
			twp_sync3 #(.RST_VAL(1'b0)) u_strap (
				.clk  (link_clk),
				.rstn (rstn),
				.din  (addr_strap_pins[gi]),
				.dout (strap_l[gi])
			);
		end
	endgenerate

	// core-side synchronisers
	twp_sync3 #(.RST_VAL(1'b0)) u_tog (
		.clk  (core_clk),
		.rstn (rstn),
		.din  (l_q.ev_tog),
		.dout (tog_c)
	);
	twp_sync3 #(.RST_VAL(1'b0)) u_lock (
		.clk  (core_clk),
		.rstn (rstn),
		.din  (l_q.rd_lock),
		.dout (lock_c)
	);

	wire scl_rise  = scl_l && !l_q.scl_prev;
	wire scl_fall  = !scl_l && l_q.scl_prev;
	wire start_det = scl_l && l_q.scl_prev && l_q.sda_prev && !sda_l;
	wire stop_det  = scl_l && l_q.scl_prev && !l_q.sda_prev && sda_l;
	wire byte_done = scl_fall && (l_q.bit_cnt == BYTE_BITS);

	// link protocol engine
	always_comb
	begin
		l_d          = l_q;
		l_d.scl_prev = scl_l;
		l_d.sda_prev = sda_l;
		if (!wp_l)
		begin
			l_d.wp_lost = 1'b1;
		end
		if (scl_rise && l_q.bit_cnt != BYTE_BITS)
		begin
			l_d.bit_cnt = l_q.bit_cnt + 1'b1;
			if (l_q.st != ST_RD_BYTE)
			begin
				l_d.shreg = {l_q.shreg[MSB-1:0], sda_l};
			end
		end
		case (l_q.st)
			ST_IDLE:
			begin
				l_d.sda_oe_n = 1'b1;
			end
			ST_ADDR:
			begin
				if (byte_done)
				begin
					if (addr_match(l_q.shreg, strap_l) && !busy_l)
					begin
						l_d.st       = ST_ADDR_ACK;
						l_d.sda_oe_n = 1'b0;
					end
					else
					begin
						l_d.st = ST_WAIT_STOP;
					end
				end
			end
			ST_ADDR_ACK:
			begin
				if (scl_fall)
				begin
					l_d.bit_cnt = '0;
					if (l_q.shreg[RW_BIT])
					begin
						l_d.st       = ST_RD_BYTE;
						l_d.shreg    = c_q.rd_hold;
						l_d.sda_oe_n = c_q.rd_hold[MSB];
					end
					else
					begin
						l_d.st       = ST_INSTR;
						l_d.sda_oe_n = 1'b1;
					end
				end
			end
			ST_INSTR:
			begin
				if (byte_done)
				begin
					l_d.instr    = l_q.shreg;
					l_d.st       = ST_INSTR_ACK;
					l_d.sda_oe_n = 1'b0;
				end
			end
			ST_INSTR_ACK, ST_DATA_ACK:
			begin
				if (scl_fall)
				begin
					l_d.bit_cnt  = '0;
					l_d.st       = ST_DATA;
					l_d.sda_oe_n = 1'b1;
				end
			end
			ST_DATA:
			begin
				if (byte_done)
				begin
					if (wp_l)
					begin
						l_d.data      = l_q.shreg;
						l_d.have_data = 1'b1;
						l_d.st        = ST_DATA_ACK;
						l_d.sda_oe_n  = 1'b0;
					end
					else
					begin
						l_d.have_data = 1'b0;
						l_d.st        = ST_WAIT_STOP;
					end
				end
			end
			ST_RD_BYTE:
			begin
				if (scl_fall)
				begin
					if (l_q.bit_cnt == BYTE_BITS)
					begin
						l_d.st       = ST_RD_ACK;
						l_d.sda_oe_n = 1'b1;
					end
					else
					begin
						l_d.shreg    = {l_q.shreg[MSB-1:0], 1'b0};
						l_d.sda_oe_n = l_q.shreg[MSB-1];
					end
				end
			end
			ST_RD_ACK:
			begin
				if (scl_rise && sda_l)
				begin
					l_d.st = ST_WAIT_STOP;
				end
				else if (scl_fall)
				begin
					l_d.bit_cnt  = '0;
					l_d.st       = ST_RD_BYTE;
					l_d.shreg    = c_q.rd_hold;
					l_d.sda_oe_n = c_q.rd_hold[MSB];
				end
			end
			ST_WAIT_STOP:
			begin
				l_d.sda_oe_n = 1'b1;
			end
			default:
			begin
				l_d.st = ST_IDLE;
			end
		endcase
		// start and stop override any state
		if (start_det)
		begin
			l_d.st        = ST_ADDR;
			l_d.bit_cnt   = '0;
			l_d.have_data = 1'b0;
			l_d.wp_lost   = !wp_l;
			l_d.rd_lock   = 1'b1;
			l_d.sda_oe_n  = 1'b1;
		end
		else if (stop_det)
		begin
			if (l_q.have_data && !(is_nv_write(l_q.instr) && l_q.wp_lost))
			begin
				l_d.ev_tog = !l_q.ev_tog;
			end
			l_d.st        = ST_IDLE;
			l_d.have_data = 1'b0;
			l_d.rd_lock   = 1'b0;
			l_d.sda_oe_n  = 1'b1;
		end
	end

	always_ff @(posedge link_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			l_q <= LINK_RST;
		end
		else
		begin
			l_q <= l_d;
		end
	end

	// core side: write delivery and read data hold
	wire ev_c = tog_c ^ c_q.tog_seen;

	always_comb
	begin
		c_d          = c_q;
		c_d.tog_seen = tog_c;
		c_d.wr_valid = ev_c;
		if (!lock_c)
		begin
			c_d.rd_hold = rd_data;
		end
		if (ev_c)
		begin
			c_d.opcode  = l_q.instr[OPC_MSB:OPC_LSB];
			c_d.reg_sel = l_q.instr[RSEL_MSB:RSEL_LSB];
			c_d.reg_onehot = 4'h1 << l_q.instr[RSEL_MSB:RSEL_LSB];
			c_d.pot_sel = l_q.instr[PSEL_MSB:PSEL_LSB];
			c_d.data    = l_q.data;
		end
	end

	assign tmr_start = ev_c && is_nv_write(l_q.instr);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			c_q <= '0;
		end
		else
		begin
			c_q <= c_d;
		end
	end

	twp_cycle_timer #(
		.LOAD_NV (NV_PROGRAM_CYCLES_P),
		.LOAD_PU (POWERUP_CYCLES_P)
	) u_tmr (
		.clk   (core_clk),
		.rstn  (rstn),
		.start (tmr_start),
		.busy  (tmr_busy)
	);

	assign sda_o                = l_q.sda_out;
	assign sda_oe_n             = l_q.sda_oe_n;
	assign wr_valid             = c_q.wr_valid;
	assign wr_opcode            = c_q.opcode;
	assign data_reg_select_bits = c_q.reg_sel;
	assign data_reg_onehot      = c_q.reg_onehot;
	assign wr_pot_sel           = c_q.pot_sel;
	assign wr_data              = c_q.data;
	assign nv_busy              = tmr_busy;

	property p_idle_wait;
		@(posedge link_clk) disable iff (!rstn)
		(l_q.st == ST_IDLE && !start_det) |=> l_q.st == ST_IDLE;
	endproperty
	a_idle_wait: assert property (p_idle_wait)
		else $error("left idle without start");

	property p_restart;
		@(posedge link_clk) disable iff (!rstn)
		start_det |=> (l_q.st == ST_ADDR && l_q.bit_cnt == 4'h0
			&& l_q.sda_oe_n);
	endproperty
	a_restart: assert property (p_restart)
		else $error("start did not restart address");

	property p_addr_ack;
		@(posedge link_clk) disable iff (!rstn)
		(l_q.st == ST_ADDR && byte_done) |=>
			(l_q.st == ST_ADDR_ACK) ==
			($past(addr_match(l_q.shreg, strap_l)) && !$past(busy_l));
	endproperty
	a_addr_ack: assert property (p_addr_ack)
		else $error("address ack does not follow match");

	property p_busy_nak;
		@(posedge link_clk) disable iff (!rstn)
		(busy_l && l_q.st == ST_ADDR && byte_done) |=>
			l_q.sda_oe_n [*2];
	endproperty
	a_busy_nak: assert property (p_busy_nak)
		else $error("address acked while busy");

	property p_ack_low;
		@(posedge link_clk) disable iff (!rstn)
		(l_q.st inside {ST_ADDR_ACK, ST_INSTR_ACK, ST_DATA_ACK})
			|-> !l_q.sda_oe_n;
	endproperty
	a_ack_low: assert property (p_ack_low)
		else $error("ack not driven low");

	property p_wp_nak;
		@(posedge link_clk) disable iff (!rstn)
		(!wp_l && l_q.st == ST_DATA && byte_done && !start_det
			&& !stop_det) |=> (l_q.st == ST_WAIT_STOP && l_q.sda_oe_n);
	endproperty
	a_wp_nak: assert property (p_wp_nak)
		else $error("protected data byte acked");

	property p_ev_at_stop;
		@(posedge link_clk) disable iff (!rstn)
		$changed(l_q.ev_tog) |-> $past(stop_det) && $past(l_q.have_data);
	endproperty
	a_ev_at_stop: assert property (p_ev_at_stop)
		else $error("write handed over without stop");

	property p_wp_abort;
		@(posedge link_clk) disable iff (!rstn)
		(stop_det && l_q.wp_lost && is_nv_write(l_q.instr))
			|=> $stable(l_q.ev_tog);
	endproperty
	a_wp_abort: assert property (p_wp_abort)
		else $error("aborted write was handed over");

	property p_rd_release;
		@(posedge link_clk) disable iff (!rstn)
		(l_q.st == ST_RD_ACK && scl_rise && sda_l && !start_det
			&& !stop_det) |=> (l_q.st == ST_WAIT_STOP && l_q.sda_oe_n);
	endproperty
	a_rd_release: assert property (p_rd_release)
		else $error("read went on after no ack");

	property p_drive_change;
		@(posedge link_clk) disable iff (!rstn)
		$changed(l_q.sda_oe_n) |-> $past(!scl_l || start_det || stop_det);
	endproperty
	a_drive_change: assert property (p_drive_change)
		else $error("data drive changed while clock high");

	property p_pulse;
		@(posedge core_clk) disable iff (!rstn)
		c_q.wr_valid |=> !c_q.wr_valid;
	endproperty
	a_pulse: assert property (p_pulse)
		else $error("write pulse longer than one cycle");

	c_nv_write: cover property (@(posedge core_clk) disable iff (!rstn)
		tmr_start);
	c_poll_nak: cover property (@(posedge link_clk) disable iff (!rstn)
		busy_l && l_q.st == ST_ADDR && byte_done);
	c_rd_nak: cover property (@(posedge link_clk) disable iff (!rstn)
		l_q.st == ST_RD_ACK && scl_rise && sda_l);

endmodule : twp_slave
`default_nettype wire

// *** twp_pkg.sv ***
// Purpose: shared constants, states and decoders of the two-wire pot slave
// Assumes: core clock 10 MHz, link sampling clock 8 MHz
// Notes:   times are kept in their own unit, cycle counts derive from them
package twp_pkg;

	// device type nibble; value is arbitrary
	localparam logic [3:0] DEV_TYPE_ID = 4'ha;

	localparam int CORE_CLK_HZ        = 10_000_000;
	localparam int NV_PROGRAM_TIME_MS = 5;
	localparam int POWERUP_READ_DELAY_MS  = 1;
	localparam int POWERUP_WRITE_DELAY_MS = 1;
	localparam int GLITCH_FILTER_TIME_NS  = 50;
	localparam int LINK_CLK_PERIOD_NS     = 125;

	// longest times, so rounded down
	localparam int NV_PROGRAM_CYCLES =
		NV_PROGRAM_TIME_MS * (CORE_CLK_HZ / 1000);
	localparam int POWERUP_DELAY_MS =
		(POWERUP_READ_DELAY_MS > POWERUP_WRITE_DELAY_MS) ?
		POWERUP_READ_DELAY_MS : POWERUP_WRITE_DELAY_MS;
	localparam int POWERUP_CYCLES =
		POWERUP_DELAY_MS * (CORE_CLK_HZ / 1000);

	localparam int TMR_W = 16;

	// byte layout
	localparam int ID_MSB    = 7;
	localparam int ID_LSB    = 4;
	localparam int STRAP_MSB = 3;
	localparam int STRAP_LSB = 0;
	localparam int RW_BIT    = 0;
	localparam int OPC_MSB   = 7;
	localparam int OPC_LSB   = 4;
	localparam int RSEL_MSB  = 3;
	localparam int RSEL_LSB  = 2;
	localparam int PSEL_MSB  = 1;
	localparam int PSEL_LSB  = 0;
	localparam int MSB       = 7;

	localparam logic [3:0] BYTE_BITS   = 4'h8;
	localparam logic [3:0] OP_WRITE_DR = 4'hc;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_ADDR,
		ST_ADDR_ACK,
		ST_INSTR,
		ST_INSTR_ACK,
		ST_DATA,
		ST_DATA_ACK,
		ST_RD_BYTE,
		ST_RD_ACK,
		ST_WAIT_STOP
	} twp_link_st_t;

	function automatic logic addr_match(input logic [7:0] b,
		input logic [3:0] strap);
		addr_match = (b[ID_MSB:ID_LSB] == DEV_TYPE_ID) &&
			(b[STRAP_MSB:STRAP_LSB] == strap);
	endfunction : addr_match

	function automatic logic is_nv_write(input logic [7:0] instr);
		is_nv_write = (instr[OPC_MSB:OPC_LSB] == OP_WRITE_DR);
	endfunction : is_nv_write

endpackage : twp_pkg

// *** twp_sync3.sv ***
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: din is asynchronous to clk
// Notes:   output moves only when stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module twp_sync3 #(
	parameter logic RST_VAL = 1'b1
)
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic din,
	output var  logic dout
);
	import twp_pkg::*;

	typedef struct packed {
		logic s1;
		logic s2;
		logic s3;
		logic filt;
	} twp_sync_t;

	twp_sync_t q;
	twp_sync_t d;

	always_comb
	begin
		d      = q;
		d.s1   = din;
		d.s2   = q.s1;
		d.s3   = q.s2;
		if (q.s2 == q.s3)
		begin
			d.filt = q.s3;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= '{s1: RST_VAL, s2: RST_VAL, s3: RST_VAL, filt: RST_VAL};
		end
		else
		begin
			q <= d;
		end
	end

	assign dout = q.filt;

endmodule : twp_sync3
`default_nettype wire

// *** twp_cycle_timer.sv ***
// Purpose: busy timer for power-up wait and nonvolatile programming
// Assumes: start is a one-cycle pulse on clk
// Notes:   busy from reset for the power-up wait; wp has no path here
`timescale 1ns/1ps
`default_nettype none
module twp_cycle_timer #(
	parameter logic [twp_pkg::TMR_W-1:0] LOAD_NV = '1,
	parameter logic [twp_pkg::TMR_W-1:0] LOAD_PU = '1
)
(
	input  wire logic clk,
	input  wire logic rstn,
	input  wire logic start,
	output var  logic busy
);
	import twp_pkg::*;

	typedef struct packed {
		logic [TMR_W-1:0] cnt;
		logic             busy;
	} twp_tmr_t;

	twp_tmr_t q;
	twp_tmr_t d;

	always_comb
	begin
		d = q;
		if (start)
		begin
			d.cnt  = LOAD_NV - 1'b1;
			d.busy = 1'b1;
		end
		else if (q.cnt != '0)
		begin
			d.cnt  = q.cnt - 1'b1;
			d.busy = (q.cnt != {{(TMR_W-1){1'b0}}, 1'b1});
		end
		else
		begin
			d.busy = 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q <= '{cnt: LOAD_PU, busy: 1'b1};
		end
		else
		begin
			q <= d;
		end
	end

	assign busy = q.busy;

	property p_nv_load;
		@(posedge clk) disable iff (!rstn)
		start |=> (q.busy && q.cnt == LOAD_NV - 1'b1);
	endproperty
	a_nv_load: assert property (p_nv_load)
		else $error("program timer not loaded");

	property p_busy_hold;
		@(posedge clk) disable iff (!rstn)
		(q.cnt > 2) |=> q.busy [*2];
	endproperty
	a_busy_hold: assert property (p_busy_hold)
		else $error("busy dropped while counting");

endmodule : twp_cycle_timer
`default_nettype wire

// *** twp_master_bfm.sv ***
// Purpose: behavioural two-wire bus master for the pot slave
// Assumes: open-drain data line with pull-up, paced by core_clk
// Notes:   clock low 1.4 us, high 1.0 us, clock idles high
`timescale 1ns/1ps
`default_nettype none
module twp_master_bfm
(
	input  wire logic clk,
	input  wire logic sda_o,
	input  wire logic sda_oe_n,
	output var  logic scl,
	output wire logic sda
);
	logic m_low;
	logic glitch;

	// wired-and with pull-up
	assign sda = (m_low || (!sda_oe_n && !sda_o)) ? 1'b0 : 1'b1;

	initial
	begin
		scl    = 1'b1;
		m_low  = 1'b0;
		glitch = 1'b0;
	end

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc

	// start, or repeated start: a low clock is first raised with data released
	task automatic start_c();
		if (scl === 1'b0)
		begin
			m_low = 1'b0;
			cyc(4);
			scl = 1'b1;
		end
		cyc(6);
		m_low = 1'b1;
		cyc(6);
		scl = 1'b0;
	endtask : start_c

	task automatic stop_c();
		cyc(4);
		m_low = 1'b1;
		cyc(10);
		scl = 1'b1;
		cyc(6);
		m_low = 1'b0;
		cyc(13);
	endtask : stop_c

	task automatic pulse(output logic s);
		cyc(10);
		scl = 1'b1;
		cyc(5);
		s = sda;
		cyc(5);
		scl = 1'b0;
	endtask : pulse

	// bits msb first, ninth clock for ack
	task automatic send_bits(input logic [7:0] b, input int n,
		output logic ack);
		logic s;
		ack = 1'b0;
		for (int i = 7; i > 7 - n; i--)
		begin
			cyc(4);
			m_low = !b[i];
			if (glitch && i == 3)
			begin
				#300;
				scl = 1'b1;
				#40;
				scl = 1'b0;
			end
			pulse(s);
		end
		if (n == 8)
		begin
			cyc(4);
			m_low = 1'b0;
			pulse(s);
			ack = !s;
		end
	endtask : send_bits

	task automatic recv_byte(input logic ack, output logic [7:0] b);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			cyc(4);
			m_low = 1'b0;
			pulse(s);
			b[i] = s;
		end
		cyc(4);
		m_low = ack;
		pulse(s);
	endtask : recv_byte
endmodule : twp_master_bfm
`default_nettype wire

// *** twp_slave_tb_top.sv ***
// Purpose: self-checking bench for the two-wire pot slave
// Assumes: shortened program and power-up counts
// Notes:   all bus traffic goes through the master model
`timescale 1ns/1ps
`default_nettype none
module twp_slave_tb_top;
	import twp_pkg::*;

	localparam logic [15:0] NV_CYC = 16'h0190;
	localparam logic [15:0] PU_CYC = 16'h000a;
	localparam int          LIMIT  = 40000;
	localparam logic [7:0]  ADR_W  = {DEV_TYPE_ID, 4'h6};

	logic       core_clk;
	logic       link_clk;
	logic       rstn;
	logic       wp_n_i;
	logic [3:0] straps;
	logic [7:0] rd_data;
	wire logic  scl;
	wire logic  sda;
	logic       sda_o;
	logic       sda_oe_n;
	logic       wr_valid;
	logic [3:0] wr_opcode;
	logic [1:0] sel;
	logic [3:0] onehot;
	logic [1:0] pot;
	logic [7:0] wr_data;
	logic       nv_busy;
	logic [15:0] cap;
	logic       k;
	logic [7:0] b;
	logic [7:0] ib;
	int         err_count = 0;
	int         n_checks  = 0;
	int         cyc_cnt   = 0;
	int         wv_cnt    = 0;
	int         wv_base   = 0;
	int         run       = 0;
	int         busy_len  = 0;

	twp_slave #(
		.NV_PROGRAM_CYCLES_P (NV_CYC),
		.POWERUP_CYCLES_P    (PU_CYC)
	) DUT (
		.core_clk             (core_clk),
		.rstn                 (rstn),
		.link_clk             (link_clk),
		.scl_i                (scl),
		.sda_i                (sda),
		.sda_o                (sda_o),
		.sda_oe_n             (sda_oe_n),
		.wp_n_i               (wp_n_i),
		.addr_strap_pins      (straps),
		.rd_data              (rd_data),
		.wr_valid             (wr_valid),
		.wr_opcode            (wr_opcode),
		.data_reg_select_bits (sel),
		.data_reg_onehot      (onehot),
		.wr_pot_sel           (pot),
		.wr_data              (wr_data),
		.nv_busy              (nv_busy)
	);

	twp_master_bfm m (
		.clk      (core_clk),
		.sda_o    (sda_o),
		.sda_oe_n (sda_oe_n),
		.scl      (scl),
		.sda      (sda)
	);

	always #50 core_clk = ~core_clk;

	initial
	begin
		link_clk = 1'b0;
		#17;
		forever #62.5 link_clk = ~link_clk;
	end

	always @(posedge core_clk)
	begin
		cyc_cnt <= cyc_cnt + 1;
		if (wr_valid === 1'b1)
		begin
			wv_cnt <= wv_cnt + 1;
			cap    <= {wr_opcode, sel, pot, wr_data};
		end
		if (nv_busy === 1'b1)
			run <= run + 1;
		else
		begin
			if (run != 0)
				busy_len <= run;
			run <= 0;
		end
		if (cyc_cnt == LIMIT)
		begin
			err_count = err_count + 1;
			$display("Error at %0t: run limit reached", $time);
			report_and_stop();
		end
	end

	task automatic report_and_stop();
		$display("Checks %0d, errors %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : report_and_stop

	task automatic chk(input logic ok, input string msg);
		n_checks++;
		if (ok !== 1'b1)
		begin
			err_count++;
			$display("Error at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic wr3(input logic [7:0] a, input logic [7:0] i,
		input logic [7:0] d, input logic [2:0] ea, input logic drop);
		logic [2:0] r;
		wv_base = wv_cnt;
		m.start_c();
		m.send_bits(a, 8, r[2]);
		m.send_bits(i, 8, r[1]);
		m.send_bits(d, 8, r[0]);
		chk(r === ea, "acknowledge pattern");
		if (drop)
			wp_n_i = 1'b0;
		m.stop_c();
	endtask : wr3

	task automatic expect_wv(input int n, input logic [15:0] f);
		m.cyc(20);
		chk(wv_cnt - wv_base == n, "handover count");
		if (n != 0)
			chk(cap === f, "handover fields");
	endtask : expect_wv

	task automatic poll(output logic a);
		m.start_c();
		m.send_bits(ADR_W, 8, a);
		m.stop_c();
	endtask : poll

	task automatic wait_idle();
		int n;
		n = 0;
		while (nv_busy !== 1'b0 && n < 2000)
		begin
			@(posedge core_clk);
			n++;
		end
		chk(nv_busy === 1'b0, "busy never ended");
		m.cyc(10);
	endtask : wait_idle

	initial
	begin
		core_clk = 1'b0;
		rstn     = 1'b0;
		wp_n_i   = 1'b1;
		straps   = 4'h6;
		rd_data  = 8'h96;
		repeat (20) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		chk(nv_busy === 1'b1, "busy during power-up");
		wait_idle();
		for (int r = 0; r < 4; r++)
		begin
			ib = {4'ha, 2'(r), 2'(3 - r)};
			wr3(ADR_W, ib, 8'h40 + 8'(r), 3'b111, 1'b0);
			expect_wv(1, {ib, 8'h40 + 8'(r)});
			chk(onehot === 4'(1 << r), "register one-hot");
			chk(nv_busy === 1'b0, "volatile write programs");
		end
		wr3({DEV_TYPE_ID, 4'h4}, 8'hc0, 8'h11, 3'b000, 1'b0);
		expect_wv(0, '0);
		wr3({DEV_TYPE_ID ^ 4'h1, 4'h6}, 8'hc0, 8'h11, 3'b000, 1'b0);
		expect_wv(0, '0);
		m.start_c();
		m.send_bits(ADR_W, 4, k);
		wr3(ADR_W, 8'ha9, 8'h21, 3'b111, 1'b0);
		expect_wv(1, 16'ha921);
		m.glitch = 1'b1;
		wr3(ADR_W, 8'ha6, 8'h5a, 3'b111, 1'b0);
		m.glitch = 1'b0;
		expect_wv(1, 16'ha65a);
		wp_n_i = 1'b0;
		wr3(ADR_W, 8'hc1, 8'h22, 3'b110, 1'b0);
		expect_wv(0, '0);
		chk(nv_busy === 1'b0, "protected write programs");
		wp_n_i = 1'b1;
		m.cyc(10);
		wr3(ADR_W, 8'hc2, 8'h33, 3'b111, 1'b1);
		expect_wv(0, '0);
		chk(nv_busy === 1'b0, "aborted write programs");
		wp_n_i = 1'b1;
		m.cyc(10);
		wr3(ADR_W, 8'hcd, 8'h3f, 3'b111, 1'b0);
		expect_wv(1, 16'hcd3f);
		chk(nv_busy === 1'b1, "program cycle running");
		poll(k);
		chk(k === 1'b0, "poll acked while busy");
		wp_n_i = 1'b0;
		wait_idle();
		chk(busy_len >= int'(NV_CYC) - 1 && busy_len <= int'(NV_CYC),
			"program cycle length");
		wp_n_i = 1'b1;
		poll(k);
		chk(k === 1'b1, "poll not acked after cycle");
		straps = 4'h7;
		m.cyc(10);
		m.start_c();
		m.send_bits({DEV_TYPE_ID, 4'h7}, 8, k);
		chk(k === 1'b1, "read address ack");
		chk(sda_o === 1'b0, "data output not low");
		m.recv_byte(1'b1, b);
		chk(b === 8'h96, "first read byte");
		m.recv_byte(1'b0, b);
		chk(b === 8'h96, "second read byte");
		m.recv_byte(1'b1, b);
		chk(b === 8'hff, "line held after nack");
		m.stop_c();
		report_and_stop();
	end
endmodule : twp_slave_tb_top
`default_nettype wire
